// file: debug_port_pkg.sv
`default_nettype none
package debug_port_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_PS = 25000;
  localparam int TRIG_PULSE_NS = 100;
  // Least time, so round up
  localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam logic [3:0] TRIG_PULSE_CNT = 4'(TRIG_PULSE_CYC);
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Pin synchroniser lanes and reset levels
  // ----------------------------------------------------------------
  localparam int SYNC_W = 3;
  localparam int LANE_TCK = 0;
  localparam int LANE_TDI = 1;
  localparam int LANE_TGL = 2;
  localparam logic [2:0] SYNC_RST_VAL = 3'h3;

  // ----------------------------------------------------------------
  // Test access port
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam int DR_W = 8;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_DBG_DATA = 4'h8;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [7:0] DR_RST_VAL = 8'h00;

  typedef enum logic [15:0] {
    TAP_RESET   = 16'h0001,
    TAP_IDLE    = 16'h0002,
    TAP_SEL_DR  = 16'h0004,
    TAP_CAP_DR  = 16'h0008,
    TAP_SH_DR   = 16'h0010,
    TAP_EX1_DR  = 16'h0020,
    TAP_PA_DR   = 16'h0040,
    TAP_EX2_DR  = 16'h0080,
    TAP_UPD_DR  = 16'h0100,
    TAP_SEL_IR  = 16'h0200,
    TAP_CAP_IR  = 16'h0400,
    TAP_SH_IR   = 16'h0800,
    TAP_EX1_IR  = 16'h1000,
    TAP_PA_IR   = 16'h2000,
    TAP_EX2_IR  = 16'h4000,
    TAP_UPD_IR  = 16'h8000
  } tap_state_t;

  // ----------------------------------------------------------------
  // Two-wire link framing
  // ----------------------------------------------------------------
  localparam logic [3:0] TW_LAST_DATA = 4'h7;
  localparam logic [3:0] TW_SEP_BIT = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef enum logic [1:0] {
    MODE_INSTR    = 2'h1,
    MODE_TWO_WIRE = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    TW_IDLE  = 2'h1,
    TW_SHIFT = 2'h2
  } tw_state_t;

endpackage
`default_nettype wire

// file: tap_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic enable;
  logic tdo;
  logic tdo_oe;
  logic upd_tgl;
  logic [7:0] upd_data;

  modport tap (
    input tck, tms, tdi, enable,
    output tdo, tdo_oe, upd_tgl, upd_data
  );
  modport top (
    output tck, tms, tdi, enable,
    input tdo, tdo_oe, upd_tgl, upd_data
  );
endinterface
`default_nettype wire

// file: pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [debug_port_pkg::SYNC_W-1:0] i_d,
  output logic [debug_port_pkg::SYNC_W-1:0] o_q
);

  typedef struct packed {
    logic [debug_port_pkg::SYNC_W-1:0] s1;
    logic [debug_port_pkg::SYNC_W-1:0] s2;
    logic [debug_port_pkg::SYNC_W-1:0] s3;
    logic [debug_port_pkg::SYNC_W-1:0] lvl;
  } sync_t;

  sync_t q, d;

  // Out of reset, level only moves once stages two and three agree
  always_comb begin
    d = q;
    d.s1 = i_d;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < debug_port_pkg::SYNC_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    // Stages keep running in reset so the strap sees the pin
    if (i_rst) begin
      q <= d;
      q.lvl <= q.s3;
    end else begin
      q <= d;
    end
  end

  assign o_q = q.lvl;

endmodule
`default_nettype wire

// file: tap_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tap_ctrl (
  tap_link_if.tap l
);

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    debug_port_pkg::tap_state_t st;
    logic [3:0] ir_sh;
    logic [3:0] ir;
    logic [7:0] dr_sh;
    logic [7:0] dr_upd;
    logic byp;
    logic upd_tgl;
  } tap_reg_t;

  tap_reg_t q, d;
  logic tdo_q;
  logic tdo_oe_q;
  logic dbg_sel;

  assign dbg_sel = (q.ir == debug_port_pkg::IR_DBG_DATA);

  // ----------------------------------------------------------------
  // Rising edge: state, capture and shift
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.en_s1 = l.enable;
    d.en_s2 = q.en_s1;
    case (q.st)
      debug_port_pkg::TAP_RESET: d.st = l.tms ? debug_port_pkg::TAP_RESET : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_IDLE: d.st = l.tms ? debug_port_pkg::TAP_SEL_DR : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_SEL_DR: d.st = l.tms ? debug_port_pkg::TAP_SEL_IR : debug_port_pkg::TAP_CAP_DR;
      debug_port_pkg::TAP_CAP_DR: d.st = l.tms ? debug_port_pkg::TAP_EX1_DR : debug_port_pkg::TAP_SH_DR;
      debug_port_pkg::TAP_SH_DR: d.st = l.tms ? debug_port_pkg::TAP_EX1_DR : debug_port_pkg::TAP_SH_DR;
      debug_port_pkg::TAP_EX1_DR: d.st = l.tms ? debug_port_pkg::TAP_UPD_DR : debug_port_pkg::TAP_PA_DR;
      debug_port_pkg::TAP_PA_DR: d.st = l.tms ? debug_port_pkg::TAP_EX2_DR : debug_port_pkg::TAP_PA_DR;
      debug_port_pkg::TAP_EX2_DR: d.st = l.tms ? debug_port_pkg::TAP_UPD_DR : debug_port_pkg::TAP_SH_DR;
      debug_port_pkg::TAP_UPD_DR: d.st = l.tms ? debug_port_pkg::TAP_SEL_DR : debug_port_pkg::TAP_IDLE;
      debug_port_pkg::TAP_SEL_IR: d.st = l.tms ? debug_port_pkg::TAP_RESET : debug_port_pkg::TAP_CAP_IR;
      debug_port_pkg::TAP_CAP_IR: d.st = l.tms ? debug_port_pkg::TAP_EX1_IR : debug_port_pkg::TAP_SH_IR;
      debug_port_pkg::TAP_SH_IR: d.st = l.tms ? debug_port_pkg::TAP_EX1_IR : debug_port_pkg::TAP_SH_IR;
      debug_port_pkg::TAP_EX1_IR: d.st = l.tms ? debug_port_pkg::TAP_UPD_IR : debug_port_pkg::TAP_PA_IR;
      debug_port_pkg::TAP_PA_IR: d.st = l.tms ? debug_port_pkg::TAP_EX2_IR : debug_port_pkg::TAP_PA_IR;
      debug_port_pkg::TAP_EX2_IR: d.st = l.tms ? debug_port_pkg::TAP_UPD_IR : debug_port_pkg::TAP_SH_IR;
      debug_port_pkg::TAP_UPD_IR: d.st = l.tms ? debug_port_pkg::TAP_SEL_DR : debug_port_pkg::TAP_IDLE;
      default: d.st = debug_port_pkg::TAP_RESET;
    endcase // R5
    case (q.st)
      debug_port_pkg::TAP_RESET: begin
        d.ir = debug_port_pkg::IR_BYPASS;
        // No reset pin; re-entering reset with the flag set gives one extra strobe
        d.dr_upd = debug_port_pkg::DR_RST_VAL;
        d.upd_tgl = 1'b0;
        d.byp = 1'b0;
      end
      debug_port_pkg::TAP_CAP_IR: begin
        d.ir_sh = debug_port_pkg::IR_CAPTURE;
      end
      debug_port_pkg::TAP_SH_IR: begin
        d.ir_sh = {l.tdi, q.ir_sh[3:1]}; // R6
      end
      debug_port_pkg::TAP_UPD_IR: begin
        d.ir = q.ir_sh;
      end
      // No boundary scan chain: every other code falls to the bypass bit
      debug_port_pkg::TAP_CAP_DR: begin
        if (dbg_sel) begin
          d.dr_sh = q.dr_upd;
        end else begin
          d.byp = 1'b0; // R15
        end
      end
      debug_port_pkg::TAP_SH_DR: begin
        if (dbg_sel) begin
          d.dr_sh = {l.tdi, q.dr_sh[7:1]}; // R6
        end else begin
          d.byp = l.tdi; // R15
        end
      end
      debug_port_pkg::TAP_UPD_DR: begin
        if (dbg_sel) begin
          d.dr_upd = q.dr_sh;
          d.upd_tgl = ~q.upd_tgl;
        end
      end
      default: begin
      end
    endcase
    if (!q.en_s2) begin
      d.st = debug_port_pkg::TAP_RESET;
      d.ir = debug_port_pkg::IR_BYPASS;
    end
  end

  always_ff @(posedge l.tck) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Falling edge: serial output only changes here
  // ----------------------------------------------------------------
  always_ff @(negedge l.tck) begin
    if (q.st == debug_port_pkg::TAP_SH_IR) begin
      tdo_q <= q.ir_sh[0]; // R7
    end else if (q.st == debug_port_pkg::TAP_SH_DR) begin
      tdo_q <= dbg_sel ? q.dr_sh[0] : q.byp; // R7
    end
    tdo_oe_q <= (q.st == debug_port_pkg::TAP_SH_IR) || (q.st == debug_port_pkg::TAP_SH_DR);
  end

  assign l.tdo = tdo_q;
  assign l.tdo_oe = tdo_oe_q;
  assign l.upd_tgl = q.upd_tgl;
  assign l.upd_data = q.dr_upd;

endmodule
`default_nettype wire

// file: debug_port_mode_select.sv
// Notes on behaviour
// [R1] Probe holds clock low before reset ends
// [R2] Clock high at reset end: two-wire mode
// [R3] Probe clock period at least two system clocks
// [R4] Test clock treated as fully asynchronous
// [R5] Mode select sampled on test clock rise
// [R6] Test data sampled on rise, input only
// [R7] Test data out changes on falling edge
// [R8] Data pin becomes two-wire bidirectional line
// [R9] Test clock pin clocks the two-wire link
// [R10] Undriven clock, select, data read high
// [R11] Trigger pulse high, otherwise output released
// [R12] Two-wire clock at most half system clock
// [R13] Probe picks clock by system clock range
// [R14] Register access without disturbing running machine
// [R15] No boundary scan register in port
// [R16] Inputs synchronised, edges found on synced clock
`timescale 1ns/100ps
`default_nettype none
module debug_port_mode_select (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  input wire logic I_TRIG_EVENT,
  input wire logic I_TW_TX_LOAD,
  input wire logic [7:0] I_TW_TX_DATA,
  output logic O_TDO,
  output logic O_TDO_OE,
  output logic O_DEBUG_DATA_LINE,
  output logic O_DEBUG_DATA_LINE_OE,
  output logic O_TRIGGER_PULSE_OUT,
  output logic O_TRIGGER_PULSE_OUT_OE,
  output logic O_INSTRUMENTATION_BLOCK_EN,
  output logic O_TWO_WIRE_DEBUG_EN,
  output logic O_MODE_VALID,
  output logic O_TW_START,
  output logic [7:0] O_TW_RX_DATA,
  output logic O_TW_RX_VALID,
  output logic O_TW_TX_READY,
  output logic [7:0] O_TAP_DATA,
  output logic O_TAP_DATA_VALID
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    debug_port_pkg::mode_t mode;
    logic mode_valid;
    logic tck_prev;
    logic tdi_prev;
    debug_port_pkg::tw_state_t tw_st;
    logic [3:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
    logic start_p;
    logic [7:0] tx_sh;
    logic tx_pend;
    logic tx_active;
    logic dl_o;
    logic dl_oe;
    logic [3:0] trig_cnt;
    logic trig;
    logic tgl_prev;
    logic [7:0] tap_data;
    logic tap_valid;
  } top_reg_t;

  top_reg_t q, d;

  tap_link_if link ();

  logic [debug_port_pkg::SYNC_W-1:0] raw_in;
  logic [debug_port_pkg::SYNC_W-1:0] sync_lvl;
  logic tck_s;
  logic tdi_s;
  logic tgl_s;
  logic tck_rise;
  logic tck_fall;
  logic tw_on;
  logic instr_on;
  logic start_cond;
  logic tx_ready;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pads pull clock and data high when undriven
  assign raw_in[debug_port_pkg::LANE_TCK] = I_TCK; // R10
  assign raw_in[debug_port_pkg::LANE_TDI] = I_TDI; // R10
  assign raw_in[debug_port_pkg::LANE_TGL] = link.upd_tgl;

  pin_sync u_sync (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .i_d(raw_in),
    .o_q(sync_lvl)
  ); // R4

  assign tck_s = sync_lvl[debug_port_pkg::LANE_TCK];
  assign tdi_s = sync_lvl[debug_port_pkg::LANE_TDI];
  assign tgl_s = sync_lvl[debug_port_pkg::LANE_TGL];

  // Edges need each clock phase to last several system clocks
  assign tck_rise = tck_s & ~q.tck_prev; // R16
  assign tck_fall = ~tck_s & q.tck_prev; // R16

  // ----------------------------------------------------------------
  // Four-wire access port on its own clock
  // ----------------------------------------------------------------
  assign link.tck = I_TCK; // R4
  assign link.tms = I_TMS;
  assign link.tdi = I_TDI; // R6
  assign link.enable = instr_on;

  tap_ctrl u_tap (
    .l(link.tap)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign instr_on = q.mode_valid && (q.mode == debug_port_pkg::MODE_INSTR);
  assign tw_on = q.mode_valid && (q.mode == debug_port_pkg::MODE_TWO_WIRE);

  // Start: data line falls while the link clock is high
  assign start_cond = tw_on && tck_s && q.tck_prev && q.tdi_prev && !tdi_s && !q.dl_oe;
  assign tx_ready = tw_on && !q.tx_pend && !q.tx_active;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.tck_prev = tck_s;
    d.tdi_prev = tdi_s;
    d.rx_valid = 1'b0;
    d.start_p = 1'b0;
    d.tap_valid = 1'b0;
    d.tgl_prev = tgl_s;

    // Two-wire byte engine, clocked by edges of the test clock pin
    case (q.tw_st)
      debug_port_pkg::TW_IDLE: begin
        if (start_cond) begin
          d.tw_st = debug_port_pkg::TW_SHIFT; // R9
          d.bit_cnt = debug_port_pkg::CNT_ZERO;
          d.start_p = 1'b1;
        end
      end
      debug_port_pkg::TW_SHIFT: begin
        if (start_cond) begin
          d.bit_cnt = debug_port_pkg::CNT_ZERO;
          d.start_p = 1'b1;
        end else if (tck_rise) begin // R9
          if (q.bit_cnt == debug_port_pkg::TW_SEP_BIT) begin
            // Separator carries no data; next byte repeats the access
            d.bit_cnt = debug_port_pkg::CNT_ZERO;
          end else begin
            d.rx_sh = {q.rx_sh[6:0], tdi_s}; // R8
            d.bit_cnt = q.bit_cnt + debug_port_pkg::CNT_ONE;
            if (q.bit_cnt == debug_port_pkg::TW_LAST_DATA) begin
              // Byte goes to the side port; the processor keeps running
              d.rx_data = {q.rx_sh[6:0], tdi_s}; // R14
              d.rx_valid = 1'b1; // R14
            end
          end
        end
      end
      default: begin
        d.tw_st = debug_port_pkg::TW_IDLE;
      end
    endcase

    // Read data, most significant bit first, moves on falling edges
    if (tx_ready && I_TW_TX_LOAD) begin
      d.tx_sh = I_TW_TX_DATA;
      d.tx_pend = 1'b1;
    end
    if (tck_fall && (q.tw_st == debug_port_pkg::TW_SHIFT)) begin
      if (q.bit_cnt == debug_port_pkg::TW_SEP_BIT) begin
        d.dl_oe = 1'b0; // R8
        d.tx_active = 1'b0;
      end else if (q.bit_cnt == debug_port_pkg::CNT_ZERO && q.tx_pend) begin
        d.tx_pend = 1'b0;
        d.tx_active = 1'b1;
        d.dl_oe = 1'b1; // R8
        d.dl_o = q.tx_sh[7];
        d.tx_sh = {q.tx_sh[6:0], 1'b0};
      end else if (q.tx_active) begin
        d.dl_o = q.tx_sh[7];
        d.tx_sh = {q.tx_sh[6:0], 1'b0};
      end
    end
    if (start_cond) begin
      d.tx_active = 1'b0;
      d.dl_oe = 1'b0;
    end
    if (!tw_on) begin
      d.tw_st = debug_port_pkg::TW_IDLE;
      d.dl_oe = 1'b0;
      d.tx_active = 1'b0;
      d.tx_pend = 1'b0;
    end

    // Trigger pulse; a new event restarts the pulse
    if (instr_on && I_TRIG_EVENT) begin
      d.trig_cnt = debug_port_pkg::TRIG_PULSE_CNT; // R11
    end else if (q.trig_cnt != debug_port_pkg::CNT_ZERO) begin
      d.trig_cnt = q.trig_cnt - debug_port_pkg::CNT_ONE;
    end
    d.trig = (d.trig_cnt != debug_port_pkg::CNT_ZERO); // R11

    // Update data is stable long before its toggle arrives here
    if (tgl_s != q.tgl_prev) begin
      d.tap_data = link.upd_data;
      d.tap_valid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      q <= '0;
      q.tw_st <= debug_port_pkg::TW_IDLE;
      q.tck_prev <= 1'b1;
      q.tdi_prev <= 1'b1;
      // Avoids a false update strobe on release
      q.tgl_prev <= tgl_s;
      // Strap follows the synced clock pin all through reset
      q.mode <= tck_s ? debug_port_pkg::MODE_TWO_WIRE : debug_port_pkg::MODE_INSTR; // R2
      q.mode_valid <= 1'b0;
    end else begin
      q <= d;
      q.mode_valid <= 1'b1; // R2
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_TDO = link.tdo; // R7
  assign O_TDO_OE = link.tdo_oe & instr_on;
  assign O_DEBUG_DATA_LINE = q.dl_o;
  assign O_DEBUG_DATA_LINE_OE = q.dl_oe; // R8
  assign O_TRIGGER_PULSE_OUT = q.trig;
  assign O_TRIGGER_PULSE_OUT_OE = q.trig; // R11
  assign O_INSTRUMENTATION_BLOCK_EN = instr_on; // R2
  assign O_TWO_WIRE_DEBUG_EN = tw_on; // R2
  assign O_MODE_VALID = q.mode_valid;
  assign O_TW_START = q.start_p;
  assign O_TW_RX_DATA = q.rx_data;
  assign O_TW_RX_VALID = q.rx_valid;
  assign O_TW_TX_READY = tx_ready;
  assign O_TAP_DATA = q.tap_data;
  assign O_TAP_DATA_VALID = q.tap_valid;

endmodule
`default_nettype wire

// file: debug_port_mode_select_tail_note.sv
`default_nettype none
`default_nettype wire

// file: dpms_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dpms_checker (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_TCK,
  input wire logic I_TRIG_EVENT,
  input wire logic O_TDO,
  input wire logic O_TDO_OE,
  input wire logic O_DEBUG_DATA_LINE,
  input wire logic O_DEBUG_DATA_LINE_OE,
  input wire logic O_TRIGGER_PULSE_OUT,
  input wire logic O_TRIGGER_PULSE_OUT_OE,
  input wire logic O_INSTRUMENTATION_BLOCK_EN,
  input wire logic O_TWO_WIRE_DEBUG_EN,
  input wire logic O_MODE_VALID,
  input wire logic O_TW_RX_VALID,
  input wire logic O_TW_TX_READY
);
  // ----------------------------------------------------------------
  // Strap level history
  // ----------------------------------------------------------------
  // No reset here: the count must run straight through reset
  logic lvl_q = 1'b0;
  logic [3:0] run_q = 4'h0;
  always_ff @(posedge I_MCLK) begin
    lvl_q <= I_TCK;
    run_q <= (I_TCK != lvl_q) ? 4'h0 : ((run_q == 4'hF) ? run_q : run_q + 4'h1);
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  sequence s_pulse;
    O_TRIGGER_PULSE_OUT [*4];
  endsequence
  sequence s_quiet;
    !I_TRIG_EVENT [*4];
  endsequence
  a_mode_strap: assert property ($fell(I_SRST) && run_q > 4'h5
    |=> O_TWO_WIRE_DEBUG_EN == lvl_q && O_INSTRUMENTATION_BLOCK_EN != lvl_q)
    else $error("mode does not follow strap level");
  a_mode_onehot: assert property (O_MODE_VALID
    |-> O_INSTRUMENTATION_BLOCK_EN != O_TWO_WIRE_DEBUG_EN)
    else $error("mode enables not exclusive");
  a_mode_stable: assert property (O_MODE_VALID && $past(O_MODE_VALID)
    |-> $stable(O_INSTRUMENTATION_BLOCK_EN) && $stable(O_TWO_WIRE_DEBUG_EN))
    else $error("mode changed outside reset");
  a_trig_len: assert property (I_TRIG_EVENT && O_INSTRUMENTATION_BLOCK_EN |=> s_pulse)
    else $error("trigger pulse too short");
  a_trig_end: assert property (s_quiet |=> !O_TRIGGER_PULSE_OUT)
    else $error("trigger pulse too long");
  a_trig_oe: assert property (O_TRIGGER_PULSE_OUT_OE == O_TRIGGER_PULSE_OUT)
    else $error("trigger enable differs from pulse");
  a_trig_mode: assert property (O_TRIGGER_PULSE_OUT |-> O_INSTRUMENTATION_BLOCK_EN)
    else $error("trigger pulse in two-wire mode");
  a_tdo_fall: assert property ($changed(O_TDO) |-> !I_TCK)
    else $error("test data out moved while clock high");
  a_tdo_mode: assert property (O_TDO_OE |-> O_INSTRUMENTATION_BLOCK_EN)
    else $error("test data out driven outside instrument mode");
  a_line_mode: assert property (O_DEBUG_DATA_LINE_OE |-> O_TWO_WIRE_DEBUG_EN)
    else $error("data line driven outside two-wire mode");
  a_line_fall: assert property (O_DEBUG_DATA_LINE_OE && $changed(O_DEBUG_DATA_LINE)
    |-> !I_TCK)
    else $error("data line moved while link clock high");
  a_rx_pulse: assert property (O_TW_RX_VALID |=> !O_TW_RX_VALID)
    else $error("receive strobe longer than one cycle");
  a_tx_mode: assert property (O_TW_TX_READY |-> O_TWO_WIRE_DEBUG_EN)
    else $error("transmit ready outside two-wire mode");
endmodule
`default_nettype wire

// file: dbg_probe.sv
`timescale 1ns/100ps
`default_nettype none
module dbg_probe (
  input wire logic i_line,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_tdi_oe
);
  logic ref_clk;
  // Odd offset keeps probe edges off the system clock edges
  initial begin
    ref_clk = 1'b0;
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_tdi_oe = 1'b1;
    #3.7;
    forever #16 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Clock phases
  // ----------------------------------------------------------------
  // 160 ns phases: slow, but each phase spans the sync latency
  task automatic phase();
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic park(input logic v);
    @(posedge ref_clk) o_tck <= v;
    phase();
  endtask

  // Data moves one step after the fall, never while the clock is high
  task automatic clk(input logic tms_v, input logic tdi_v, input logic oe, output logic smp);
    o_tck <= 1'b0;
    @(posedge ref_clk);
    o_tms <= tms_v;
    o_tdi <= tdi_v;
    o_tdi_oe <= oe;
    phase();
    o_tck <= 1'b1;
    smp = oe ? i_tdo : i_line;
    phase();
  endtask

  task automatic start();
    o_tdi <= 1'b1;
    o_tdi_oe <= 1'b1;
    phase();
    o_tdi <= 1'b0;
    phase();
  endtask

  task automatic frame(input logic [7:0] d, input logic oe, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk(1'b1, d[i], oe, s);
      q[i] = s;
    end
    clk(1'b1, 1'b1, oe, s);
  endtask

  task automatic scan(input logic ir, input logic [7:0] d, input int n, output logic [7:0] q);
    logic s;
    q = 8'h00;
    clk(1'b1, 1'b1, 1'b1, s);
    if (ir) clk(1'b1, 1'b1, 1'b1, s);
    clk(1'b0, 1'b1, 1'b1, s);
    clk(1'b0, 1'b1, 1'b1, s);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, d[i], 1'b1, s);
      q[i] = s;
    end
    clk(1'b1, 1'b1, 1'b1, s);
    clk(1'b0, 1'b1, 1'b1, s);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h want %h", $time, g, e); end end
module tb_top;
  logic mclk, srst, trig_ev, tx_load, tck, tms, p_tdi, p_oe, tdi_line, tdo, tdo_oe;
  logic dl, dl_oe, tp, tp_oe, ien, twen, mvalid, tw_start, rx_valid, tx_ready, tap_valid;
  logic [7:0] tx_data, rx_data, tap_data, a, b, q;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int n_start = 0;
  int seed;

  // Design output wins over the probe; nobody driving reads as pull-up
  assign tdi_line = dl_oe ? dl : (p_oe ? p_tdi : 1'b1);

  debug_port_mode_select uut (.I_MCLK(mclk), .I_SRST(srst), .I_TCK(tck), .I_TMS(tms),
    .I_TDI(tdi_line), .I_TRIG_EVENT(trig_ev), .I_TW_TX_LOAD(tx_load), .I_TW_TX_DATA(tx_data),
    .O_TDO(tdo), .O_TDO_OE(tdo_oe), .O_DEBUG_DATA_LINE(dl), .O_DEBUG_DATA_LINE_OE(dl_oe),
    .O_TRIGGER_PULSE_OUT(tp), .O_TRIGGER_PULSE_OUT_OE(tp_oe), .O_INSTRUMENTATION_BLOCK_EN(ien),
    .O_TWO_WIRE_DEBUG_EN(twen), .O_MODE_VALID(mvalid), .O_TW_START(tw_start),
    .O_TW_RX_DATA(rx_data), .O_TW_RX_VALID(rx_valid), .O_TW_TX_READY(tx_ready),
    .O_TAP_DATA(tap_data), .O_TAP_DATA_VALID(tap_valid));
  dbg_probe probe (.i_line(tdi_line), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(p_tdi),
    .o_tdi_oe(p_oe));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  task automatic pop(input logic [7:0] v);
    logic [7:0] w;
    if (exp_q.size() == 0) begin
      n_errors++;
      $display("Error at %0t: unexpected byte %h", $time, v);
    end else begin
      w = exp_q.pop_front();
      `CHK(v, w)
    end
  endtask
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) pop(rx_data);
    if (tap_valid === 1'b1) pop(tap_data);
    if (tw_start === 1'b1) n_start++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Reset is stretched past the strap sync latency
  task automatic do_reset(input logic lvl);
    probe.park(lvl);
    @(posedge mclk) srst <= 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic trig(input int gap, input int want);
    int n;
    n = 0;
    for (int k = 0; k < gap + 14; k++) begin
      @(posedge mclk) trig_ev <= (k == 0 || k == gap);
      if (tp === 1'b1) n++;
    end
    `CHK(n, want)
  endtask
  task automatic wrap_up();
    $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic s;
    seed = 32'h856BC3C2;
    srst = 1'b1;
    trig_ev = 1'b0;
    tx_load = 1'b0;
    tx_data = 8'h00;
    do_reset(1'b0);
    `CHK({ien, twen, mvalid}, 3'h5)
    trig(0, int'(debug_port_pkg::TRIG_PULSE_CNT));
    trig(2, int'(debug_port_pkg::TRIG_PULSE_CNT) + 2);
    repeat (5) probe.clk(1'b1, 1'b1, 1'b1, s);
    probe.clk(1'b0, 1'b1, 1'b1, s);
    probe.scan(1'b1, {4'h0, debug_port_pkg::IR_DBG_DATA}, debug_port_pkg::IR_W, q);
    a = 8'($random(seed));
    b = 8'($random(seed));
    exp_q.push_back(a);
    probe.scan(1'b0, a, debug_port_pkg::DR_W, q);
    exp_q.push_back(b);
    probe.scan(1'b0, b, debug_port_pkg::DR_W, q);
    `CHK(q, a)
    repeat (10) @(posedge mclk);
    do_reset(1'b1);
    `CHK({ien, twen, mvalid}, 3'h3)
    trig(0, 0);
    probe.start();
    exp_q.push_back(a);
    probe.frame(a, 1'b1, q);
    @(posedge mclk);
    for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) @(posedge mclk);
    `CHK(tx_ready, 1'b1)
    tx_data <= b;
    tx_load <= 1'b1;
    @(posedge mclk) tx_load <= 1'b0;
    exp_q.push_back(b);
    probe.frame(8'hFF, 1'b0, q);
    `CHK(q, b)
    repeat (10) @(posedge mclk);
    `CHK(n_start, 1)
    `CHK(exp_q.size(), 0)
    wrap_up();
  end

  initial begin
    repeat (6000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
endmodule

bind debug_port_mode_select dpms_checker chk (.I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_TCK(I_TCK),
  .I_TRIG_EVENT(I_TRIG_EVENT), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE),
  .O_DEBUG_DATA_LINE(O_DEBUG_DATA_LINE), .O_DEBUG_DATA_LINE_OE(O_DEBUG_DATA_LINE_OE),
  .O_TRIGGER_PULSE_OUT(O_TRIGGER_PULSE_OUT), .O_TRIGGER_PULSE_OUT_OE(O_TRIGGER_PULSE_OUT_OE),
  .O_INSTRUMENTATION_BLOCK_EN(O_INSTRUMENTATION_BLOCK_EN),
  .O_TWO_WIRE_DEBUG_EN(O_TWO_WIRE_DEBUG_EN), .O_MODE_VALID(O_MODE_VALID),
  .O_TW_RX_VALID(O_TW_RX_VALID), .O_TW_TX_READY(O_TW_TX_READY));
`default_nettype wire
